//--- hw/ahi_regs.vh
`ifndef AHI_REGS_VH
`define AHI_REGS_VH

`define AHI_ADDR_W          6
`define AHI_DATA_W          24
`define AHI_OFS_UPPER       6'h2B
`define AHI_OFS_LOWER       6'h2C
`define AHI_OFS_TEMPCO      6'h2D
`define AHI_OFS_XTALK       6'h2E
`define AHI_OFS_MODE        6'h30
`define AHI_RST_UPPER       24'h006000
`define AHI_RST_LOWER       24'h000800
`define AHI_RST_TEMPCO      24'h000000
`define AHI_RST_XTALK       24'h8001A0
`define AHI_RST_MODE        24'h000000
`define AHI_THR_MSB         15
`define AHI_THR_LSB         0
`define AHI_SCALE_H_MSB     21
`define AHI_SCALE_H_LSB     19
`define AHI_SCALE_L_MSB     18
`define AHI_SCALE_L_LSB     16
`define AHI_RSVD_MASK       24'h3FFFFF
`define AHI_TC_HI_MSB       23
`define AHI_TC_HI_LSB       12
`define AHI_TC_LO_MSB       11
`define AHI_TC_LO_LSB       0
`define AHI_TAU_MSB         23
`define AHI_TAU_LSB         20
`define AHI_XT_MASK         24'hFFDFFF
`define AHI_MODE_EN_BIT     0
`define AHI_MODE_SEL_BIT    1
`define AHI_MODE_MASK       24'h000003
`define AHI_SETTLE_TAUS     20'h00005

`endif

//--- hw/ahi_scale_dec.v
`include "ahi_regs.vh"
module ahi_scale_dec (
	input  wire [2:0]  code,
	output reg  [7:0]  current_tenth_ma,
	output reg         invalid
);
	// Tenths of a milliamp per scale code
	always @* begin
		invalid = 1'b0;
		case (code)
			3'h0: current_tenth_ma = 8'h38;
			3'h1: current_tenth_ma = 8'h2A;
			3'h2: current_tenth_ma = 8'h1C;
			3'h3: current_tenth_ma = 8'h0E;
			default: begin
				current_tenth_ma = 8'h00;
				invalid          = 1'b1;
			end
		endcase
	end
endmodule

//--- hw/ahi_top.v
// Strobed register access is this design's own decision.
`include "ahi_regs.vh"
module ahi_top (
	input  wire        sys_clk,
	input  wire        rstn,
	input  wire [5:0]  reg_addr,
	input  wire [23:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [23:0] reg_rdata,
	input  wire        frame_done,
	input  wire [15:0] frame_amplitude,
	input  wire        active_channel,
	output reg         high_current_q,
	output reg  [7:0]  channel_current_tenth_ma,
	output reg         scale_invalid,
	output reg  [11:0] phase_temp_coeff,
	output reg         phase_temp_coeff_valid,
	output reg  [19:0] crosstalk_settle_frames
);
	localparam ST_LOW  = 1'b0;
	localparam ST_HIGH = 1'b1;

	reg  [23:0] upper_q;
	reg  [23:0] lower_q;
	reg  [23:0] tempco_q;
	reg  [23:0] xtalk_q;
	reg  [23:0] mode_q;
	reg         cur_d;
	reg  [11:0] coeff_d;
	reg         coeff_valid_d;
	wire        adaptive_current_enable;
	wire        fixed_current_select;
	wire [15:0] upper_amplitude_threshold;
	wire [15:0] lower_amplitude_threshold;
	wire [2:0]  ch0_code;
	wire [2:0]  ch1_code;
	wire [2:0]  sel_code;
	wire [7:0]  dec_ma;
	wire        dec_inv;
	wire [3:0]  crosstalk_filter_tau_exp;
	wire        wr_upper;
	wire        wr_lower;
	wire        wr_tempco;
	wire        wr_xtalk;
	wire        wr_mode;

	// Strobe qualified by one register offset
	function addr_hit;
		input       strobe;
		input [5:0] a;
		input [5:0] ofs;
		begin
			addr_hit = strobe && (a == ofs);
		end
	endfunction

	// Read data of one register offset
	function [23:0] rd_mux;
		input [5:0] a;
		begin
			case (a)
				`AHI_OFS_UPPER:  rd_mux = upper_q;
				`AHI_OFS_LOWER:  rd_mux = lower_q;
				`AHI_OFS_TEMPCO: rd_mux = tempco_q;
				`AHI_OFS_XTALK:  rd_mux = xtalk_q;
				`AHI_OFS_MODE:   rd_mux = mode_q;
				default:         rd_mux = 24'h000000;
			endcase
		end
	endfunction

	// Scale field of one channel for the current setting
	function [2:0] pick_scale;
		input [23:0] r;
		input        hi;
		begin
			if (hi)
				pick_scale = r[`AHI_SCALE_H_MSB:`AHI_SCALE_H_LSB];
			else
				pick_scale = r[`AHI_SCALE_L_MSB:`AHI_SCALE_L_LSB];
		end
	endfunction

	// Five filter time constants, each two to the exponent frames
	function [19:0] settle_frames;
		input [3:0] tau;
		begin
			settle_frames = (20'h00001 << tau) * `AHI_SETTLE_TAUS;
		end
	endfunction

	assign adaptive_current_enable   = mode_q[`AHI_MODE_EN_BIT];
	assign fixed_current_select      = mode_q[`AHI_MODE_SEL_BIT];
	assign upper_amplitude_threshold = upper_q[`AHI_THR_MSB:`AHI_THR_LSB];
	assign lower_amplitude_threshold = lower_q[`AHI_THR_MSB:`AHI_THR_LSB];
	assign crosstalk_filter_tau_exp  = xtalk_q[`AHI_TAU_MSB:`AHI_TAU_LSB];

	// Write strobes decoded per register
	assign wr_upper  = addr_hit(reg_wr, reg_addr, `AHI_OFS_UPPER);
	assign wr_lower  = addr_hit(reg_wr, reg_addr, `AHI_OFS_LOWER);
	assign wr_tempco = addr_hit(reg_wr, reg_addr, `AHI_OFS_TEMPCO);
	assign wr_xtalk  = addr_hit(reg_wr, reg_addr, `AHI_OFS_XTALK);
	assign wr_mode   = addr_hit(reg_wr, reg_addr, `AHI_OFS_MODE);

	// Upper threshold and channel 0 scales; reserved bits kept at zero
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			upper_q <= `AHI_RST_UPPER;
		else if (wr_upper)
			upper_q <= reg_wdata & `AHI_RSVD_MASK;
	end

	// Lower threshold and channel 1 scales; reserved bits kept at zero
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			lower_q <= `AHI_RST_LOWER;
		else if (wr_lower)
			lower_q <= reg_wdata & `AHI_RSVD_MASK;
	end

	// Phase temperature coefficients of both channels
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			tempco_q <= `AHI_RST_TEMPCO;
		else if (wr_tempco)
			tempco_q <= reg_wdata;
	end

	// Crosstalk control; bit 13 kept at zero
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			xtalk_q <= `AHI_RST_XTALK;
		else if (wr_xtalk)
			xtalk_q <= reg_wdata & `AHI_XT_MASK;
	end

	// Adaptive enable and fixed current select
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			mode_q <= `AHI_RST_MODE;
		else if (wr_mode)
			mode_q <= reg_wdata & `AHI_MODE_MASK;
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			reg_rdata <= 24'h000000;
		else if (reg_rd)
			reg_rdata <= rd_mux(reg_addr);
		else
			reg_rdata <= 24'h000000;
	end

	// Current setting state, updated only on a completed frame
	always @* begin
		cur_d = high_current_q;
		if (!adaptive_current_enable) begin
			cur_d = fixed_current_select;
		end else if (frame_done) begin
			case (high_current_q)
				ST_HIGH: if (frame_amplitude > upper_amplitude_threshold) cur_d = ST_LOW;
				ST_LOW:  if (frame_amplitude < lower_amplitude_threshold) cur_d = ST_HIGH;
				default: cur_d = ST_LOW;
			endcase
		end
	end

	// Fixed select also takes effect at a frame boundary
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			high_current_q <= ST_LOW;
		else if (frame_done)
			high_current_q <= cur_d;
	end

	// Scale code of the active channel
	assign ch0_code = pick_scale(upper_q, high_current_q);
	assign ch1_code = pick_scale(lower_q, high_current_q);
	assign sel_code = active_channel ? ch1_code : ch0_code;

	ahi_scale_dec u_dec (
		.code             (sel_code),
		.current_tenth_ma (dec_ma),
		.invalid          (dec_inv)
	);

	// Coefficient of the active channel and setting; other pairs carry none
	always @* begin
		coeff_d       = 12'h000;
		coeff_valid_d = 1'b0;
		if (active_channel && !high_current_q) begin
			coeff_d       = tempco_q[`AHI_TC_HI_MSB:`AHI_TC_HI_LSB];
			coeff_valid_d = 1'b1;
		end else if (!active_channel && high_current_q) begin
			coeff_d       = tempco_q[`AHI_TC_LO_MSB:`AHI_TC_LO_LSB];
			coeff_valid_d = 1'b1;
		end
	end

	// Scale current toward the driver
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			channel_current_tenth_ma <= 8'h00;
			scale_invalid            <= 1'b0;
		end else begin
			channel_current_tenth_ma <= dec_ma;
			scale_invalid            <= dec_inv;
		end
	end

	// Coefficient toward the phase correction path
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			phase_temp_coeff       <= 12'h000;
			phase_temp_coeff_valid <= 1'b0;
		end else begin
			phase_temp_coeff       <= coeff_d;
			phase_temp_coeff_valid <= coeff_valid_d;
		end
	end

	// Settling time of the crosstalk filter
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			crosstalk_settle_frames <= 20'h00000;
		else
			crosstalk_settle_frames <= settle_frames(crosstalk_filter_tau_exp);
	end
endmodule

//--- tb/ahi_frm.sv
module ahi_frm (
	input  wire logic        sys_clk,
	output logic             frame_done,
	output logic [15:0]      frame_amplitude
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frame_done = 1'b0;
		frame_amplitude = 16'h5A5A;
	end
	// One frame pulse, then the amplitude turns to garbage
	task send(input [15:0] x);
		@(posedge sys_clk);
		frame_done <= 1'b1;
		frame_amplitude <= x;
		@(posedge sys_clk);
		frame_done <= 1'b0;
		frame_amplitude <= ~x;
	endtask
endmodule

//--- tb/ahi_top_sva.sv
module ahi_chk (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        frame_done,
	input wire logic        high_current_q,
	input wire logic        scale_invalid,
	input wire logic [5:0]  reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic [23:0] reg_rdata,
	input wire logic [15:0] frame_amplitude,
	input wire logic [7:0]  channel_current_tenth_ma,
	input wire logic [19:0] crosstalk_settle_frames
);
	reg [15:0] up_q, lo_q;
	reg [1:0]  md_q;
	// Shadow of thresholds and mode
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			up_q <= 16'h6000;
			lo_q <= 16'h0800;
			md_q <= 2'h0;
		end else if (reg_wr) begin
			if (reg_addr == 6'h2B) up_q <= reg_wdata[15:0];
			if (reg_addr == 6'h2C) lo_q <= reg_wdata[15:0];
			if (reg_addr == 6'h30) md_q <= reg_wdata[1:0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_over;
		frame_done && md_q[0] && high_current_q && frame_amplitude > up_q;
	endsequence
	sequence s_under;
		frame_done && md_q[0] && !high_current_q && frame_amplitude < lo_q;
	endsequence
	AST_HI_TO_LO: assert property (s_over |=> !high_current_q)
		else $error("no switch to low current");
	AST_LO_TO_HI: assert property (s_under |=> high_current_q)
		else $error("no switch to high current");
	AST_HOLD: assert property (!frame_done |=> $stable(high_current_q))
		else $error("current changed between frames");
	AST_FIXED: assert property (frame_done && !md_q[0] |=> high_current_q == md_q[1])
		else $error("fixed select ignored");
	AST_RSVD: assert property (reg_rd && reg_addr inside {6'h2B, 6'h2C} |=> reg_rdata[23:22] == 2'h0)
		else $error("reserved bits not zero");
	AST_SCALE: assert property (scale_invalid |-> channel_current_tenth_ma == 8'h00)
		else $error("invalid scale gives current");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 24'h000000)
		else $error("read data outside read slot");
	AST_XT: assert property (crosstalk_settle_frames % 5 == 0 && $onehot0(crosstalk_settle_frames / 5))
		else $error("settle count not five taus");
endmodule
bind ahi_top ahi_chk chk (
	.sys_clk                  (sys_clk),
	.rstn                     (rstn),
	.reg_wr                   (reg_wr),
	.reg_rd                   (reg_rd),
	.frame_done               (frame_done),
	.high_current_q           (high_current_q),
	.scale_invalid            (scale_invalid),
	.reg_addr                 (reg_addr),
	.reg_wdata                (reg_wdata),
	.reg_rdata                (reg_rdata),
	.frame_amplitude          (frame_amplitude),
	.channel_current_tenth_ma (channel_current_tenth_ma),
	.crosstalk_settle_frames  (crosstalk_settle_frames)
);

//--- tb/ahi_top_test.sv
module ahi_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic c = 0, rstn = 0, w = 0, r = 0, ch = 0;
	logic [5:0] a = 6'h00;
	logic [23:0] d = 24'h000000;
	logic [7:0] ex [5] = '{8'h38, 8'h2A, 8'h1C, 8'h0E, 8'h00};
	wire [23:0] q;
	wire fd, hi, inv, tv;
	wire [15:0] amp;
	wire [7:0] cur;
	wire [11:0] tc;
	wire [19:0] st;
	int bad_count = 0, cmp_count = 0, cyc = 0;
	initial forever #10 c = ~c;
	ahi_top dut (.sys_clk(c), .rstn(rstn), .reg_addr(a), .reg_wdata(d), .reg_wr(w), .reg_rd(r), .reg_rdata(q),
		.frame_done(fd), .frame_amplitude(amp), .active_channel(ch), .high_current_q(hi),
		.channel_current_tenth_ma(cur), .scale_invalid(inv), .phase_temp_coeff(tc),
		.phase_temp_coeff_valid(tv), .crosstalk_settle_frames(st));
	ahi_frm frm (.sys_clk(c), .frame_done(fd), .frame_amplitude(amp));
	task chk(input [23:0] g, input [23:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input [5:0] x, input [23:0] y);
		@(posedge c);
		a <= x; d <= y; w <= 1'b1;
		@(posedge c);
		w <= 1'b0;
	endtask
	task rd(input [5:0] x, input [23:0] e);
		@(posedge c);
		a <= x; r <= 1'b1;
		@(posedge c);
		r <= 1'b0;
		#1 chk(q, e);
	endtask
	task frame(input [15:0] x, input e);
		frm.send(x);
		#1 chk(hi, e);
	endtask
	task settle(input [23:0] g_unused);
		repeat (2) @(posedge c);
		#1;
	endtask
	task give_verdict;
		$display("mismatches %0d comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge c) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (3) @(posedge c);
		rstn <= 1'b1;
		rd(6'h2B, 24'h006000);
		rd(6'h2C, 24'h000800);
		rd(6'h2D, 24'h000000);
		rd(6'h2E, 24'h8001A0);
		chk(st, 24'h000500);
		wr(6'h2E, 24'h3001A0);
		settle(q);
		chk(st, 24'h000028);
		wr(6'h2B, 24'h3FFFFF);
		rd(6'h2B, 24'h3FFFFF);
		wr(6'h31, 24'h123456);
		rd(6'h31, 24'h000000);
		wr(6'h2B, 24'h006000);
		wr(6'h30, 24'h000001);
		frame(16'h0800, 1'b0);
		frame(16'h07FF, 1'b1);
		frame(16'h6000, 1'b1);
		frame(16'h6001, 1'b0);
		wr(6'h30, 24'h000002);
		frame(16'hFFFF, 1'b1);
		for (int i = 0; i < 5; i++) begin
			wr(6'h2B, {2'h0, i[2:0], 3'h0, 16'h6000});
			settle(q);
			chk(cur, ex[i]);
			chk(inv, i > 3);
		end
		wr(6'h2D, 24'hABC123);
		settle(q);
		chk(tc, 24'h000123);
		chk(tv, 24'h000001);
		wr(6'h30, 24'h000000);
		wr(6'h2C, {8'h03, 16'h0800});
		frame(16'h0000, 1'b0);
		@(posedge c);
		ch <= 1'b1;
		settle(q);
		chk(tc, 24'h000ABC);
		chk(tv, 24'h000001);
		chk(cur, 24'h00000E);
		wr(6'h2B, {8'h02, 16'h6000});
		ch <= 1'b0;
		settle(q);
		chk(cur, 24'h00001C);
		wr(6'h2C, {8'h10, 16'h0800});
		wr(6'h30, 24'h000002);
		frame(16'h0000, 1'b1);
		@(posedge c);
		ch <= 1'b1;
		settle(q);
		chk(cur, 24'h00001C);
		chk(tv, 24'h000000);
		give_verdict;
	end
endmodule
